// ---- i2cpsf_pkg.sv ----
/*
  Shared constants, types and register map of the two-wire port status block.
  Assumes a 32-bit AXI4-Lite register bus and one link clock beside it.
*/
package i2cpsf_pkg;
  // ==========================================================================
  // Register map (byte addresses) and field positions
  localparam logic [7:0] I2CPSF_OFS_STATUS = 8'h00;
  localparam logic [7:0] I2CPSF_OFS_CTRL1 = 8'h04;
  localparam logic [7:0] I2CPSF_OFS_CTRL2 = 8'h08;
  localparam logic [7:0] I2CPSF_OFS_BUFFER = 8'h0C;
  localparam logic [7:0] I2CPSF_OFS_OWNADDR = 8'h10;
  localparam logic [7:0] I2CPSF_OFS_IRQ = 8'h14;
  localparam logic [7:0] I2CPSF_CTRL1_RST = 8'h00;
  localparam int I2CPSF_ST_FULL = 0;
  localparam int I2CPSF_ST_RW = 2;
  localparam int I2CPSF_ST_START = 3;
  localparam int I2CPSF_ST_STOP = 4;
  localparam int I2CPSF_C1_WCOL = 7;
  localparam int I2CPSF_C1_OVF = 6;
  localparam int I2CPSF_C1_EN = 5;
  localparam int I2CPSF_IRQ_ACTIVE = 1;
  localparam logic [3:0] I2CPSF_MODE_MASTER = 4'b1000;
  localparam logic [3:0] I2CPSF_MODE_FWMASTER = 4'b1011;
  localparam logic [1:0] I2CPSF_RESP_OKAY = 2'b00;
  localparam logic [1:0] I2CPSF_RESP_SLVERR = 2'b10;
  localparam logic [8:0] I2CPSF_OUT_IDLE = 9'h1FF;
  localparam logic [3:0] I2CPSF_BITS_TX = 4'h9;
  localparam logic [3:0] I2CPSF_BITS_RX = 4'h8;
  localparam logic [3:0] I2CPSF_BITS_ACK = 4'h1;
  // ==========================================================================
  // Timing: half a bus bit at 100 kHz, counted on the 30 ns link clock
  localparam int I2CPSF_HALF_BIT_NS = 5000;
  localparam int I2CPSF_LINK_PERIOD_NS = 30;
  localparam int I2CPSF_HALF_BIT_CYC = I2CPSF_HALF_BIT_NS / I2CPSF_LINK_PERIOD_NS;
  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    I2CPSF_CMD_ADDR = 3'b000, I2CPSF_CMD_START = 3'b001, I2CPSF_CMD_RSTART = 3'b010,
    I2CPSF_CMD_STOP = 3'b011, I2CPSF_CMD_TX = 3'b100, I2CPSF_CMD_RX = 3'b101,
    I2CPSF_CMD_ACK = 3'b110
  } i2cpsf_cmd_kind_t;
  typedef struct packed {
    i2cpsf_cmd_kind_t kind;
    logic [7:0] data;
  } i2cpsf_cmd_t;
  typedef struct packed {
    logic start;
    logic stop;
    logic match;
    logic rx;
    logic txd;
    logic nack;
    logic ack;
  } i2cpsf_evt_t;
  typedef enum logic [2:0] {
    I2CPSF_L_IDLE = 3'b000, I2CPSF_L_ST1 = 3'b001, I2CPSF_L_ST2 = 3'b010,
    I2CPSF_L_LO = 3'b011, I2CPSF_L_HI = 3'b100, I2CPSF_L_SP1 = 3'b101,
    I2CPSF_L_SP2 = 3'b110
  } i2cpsf_lstate_t;
endpackage : i2cpsf_pkg

// ---- i2cpsf_sync.sv ----
/*
  Three-flop synchroniser for a group of levels or toggles.
  Assumes each bit is a level or toggle that holds for several destination clocks.
*/
module i2cpsf_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  if (W < 1) begin : g_bad_width
    $error("W must be at least 1");
  end
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  // No reset on purpose: the chain also carries the reset itself and settles in four edges.
  always_ff @(posedge clk) begin
    s1_q <= din;
    s2_q <= s1_q;
    s3_q <= s2_q;
    // Each bit moves on its own once its second and third stage agree.
    out_q <= (s3_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
  end
  assign dout = out_q;
endmodule : i2cpsf_sync

// ---- i2cpsf_top.sv ----
/*
  Status flags and minimal byte engine of a two-wire serial port, AXI4-Lite slave.
  Assumes scl and sda are open-drain wires resolved outside, sampled on link_clk.
*/
// Behaviour
// - The start flag is set and the stop flag cleared by the latest Start, the reverse by the latest Stop, both cleared by reset and by disabling.
// - As slave, the direction bit of the last matched address is held in the direction flag until the next Start, Stop or not-acknowledge.
// - As master, the direction flag is 1 while a transmission runs, and ORed with the request bits it shows the port is active.
// - While transmitting, buffer full is 1 while the buffer holds an unsent byte and 0 once it is empty.
// - With port enable set the port owns the clock and data pins, otherwise it lets them go.
// - A completed received byte is moved into the transfer buffer and sets the port interrupt flag.
module i2cpsf_top
  import i2cpsf_pkg::*;
#(
  parameter int HALF_BIT = I2CPSF_HALF_BIT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe,
  output logic sda_oe,
  output logic port_owns_pins
);
  if (HALF_BIT < 2 || HALF_BIT > 65535) begin : g_bad_half_bit
    $error("HALF_BIT out of range");
  end
  // ==========================================================================
  // Register bus
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q;
  logic [7:0] waddr_q;
  logic [7:0] wdat_q;
  logic wlane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] ctrl1_q, addr_q, buf_q, stat_hi_q;
  logic [4:0] req_q;
  logic start_q, stop_q, rw_q, bf_q, ifl_q, mtx_q, addr_dirty_q, txp_q;
  logic cmd_tog_q;
  i2cpsf_cmd_t cmd_q;
  i2cpsf_evt_t evs, evp_q, ev;
  wire do_wr = aw_have_q & w_have_q & ~bvalid_q;
  wire do_rd = s_axi_arvalid & arready_q;
  wire wr_hit = (waddr_q <= I2CPSF_OFS_IRQ) & (waddr_q[1:0] == 2'b00);
  wire rd_hit = (s_axi_araddr <= I2CPSF_OFS_IRQ) & (s_axi_araddr[1:0] == 2'b00);
  wire wr_en = do_wr & wlane_q;
  wire wr_c1 = wr_en & (waddr_q == I2CPSF_OFS_CTRL1);
  wire wr_c2 = wr_en & (waddr_q == I2CPSF_OFS_CTRL2);
  wire wr_buf = wr_en & (waddr_q == I2CPSF_OFS_BUFFER);
  wire wr_adr = wr_en & (waddr_q == I2CPSF_OFS_OWNADDR);
  wire wr_irq = wr_en & (waddr_q == I2CPSF_OFS_IRQ);
  wire wr_st = wr_en & (waddr_q == I2CPSF_OFS_STATUS);
  wire rd_buf = do_rd & (s_axi_araddr == I2CPSF_OFS_BUFFER);
  wire en = ctrl1_q[I2CPSF_C1_EN];
  wire master = (ctrl1_q[3:0] == I2CPSF_MODE_MASTER) | (ctrl1_q[3:0] == I2CPSF_MODE_FWMASTER);
  wire active = mtx_q | (|req_q);
  wire [7:0] status = {stat_hi_q[7:6], 1'b0, stop_q, start_q, rw_q, 1'b0, bf_q};
  wire [7:0] rd_mux =
    (s_axi_araddr == I2CPSF_OFS_STATUS) ? status :
    (s_axi_araddr == I2CPSF_OFS_CTRL1) ? ctrl1_q :
    (s_axi_araddr == I2CPSF_OFS_CTRL2) ? {3'b000, req_q} :
    (s_axi_araddr == I2CPSF_OFS_BUFFER) ? buf_q :
    (s_axi_araddr == I2CPSF_OFS_OWNADDR) ? addr_q : {6'b00_0000, active, ifl_q};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      waddr_q <= 8'h00;
      wdat_q <= 8'h00;
      wlane_q <= 1'b0;
      bresp_q <= I2CPSF_RESP_OKAY;
      rresp_q <= I2CPSF_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid & awready_q) begin
        awready_q <= 1'b0;
        aw_have_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & wready_q) begin
        wready_q <= 1'b0;
        w_have_q <= 1'b1;
        wdat_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? I2CPSF_RESP_OKAY : I2CPSF_RESP_SLVERR;
      end else if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
      if (do_rd) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= {24'h00_0000, rd_hit ? rd_mux : 8'h00};
        rresp_q <= rd_hit ? I2CPSF_RESP_OKAY : I2CPSF_RESP_SLVERR;
      end else if (rvalid_q & s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end
  // ==========================================================================
  // Flags, commands and events on the bus clock
  wire cmd_busy;
  wire [2:0] issue_kind =
    addr_dirty_q ? I2CPSF_CMD_ADDR : req_q[0] ? I2CPSF_CMD_START :
    req_q[1] ? I2CPSF_CMD_RSTART : req_q[2] ? I2CPSF_CMD_STOP :
    txp_q ? I2CPSF_CMD_TX : req_q[3] ? I2CPSF_CMD_RX : I2CPSF_CMD_ACK;
  wire issue = en & ~cmd_busy & (addr_dirty_q | txp_q | (|req_q));
  assign ev = evs ^ evp_q;
  // Only the request bit of the command that just finished is cleared; a transmit owns none.
  wire [4:0] req_done =
    ~ev.ack ? 5'b0_0000 :
    (cmd_q.kind == I2CPSF_CMD_START) ? 5'b0_0001 : (cmd_q.kind == I2CPSF_CMD_RSTART) ? 5'b0_0010 :
    (cmd_q.kind == I2CPSF_CMD_STOP) ? 5'b0_0100 : (cmd_q.kind == I2CPSF_CMD_RX) ? 5'b0_1000 :
    (cmd_q.kind == I2CPSF_CMD_ACK) ? 5'b1_0000 : 5'b0_0000;
  logic rx_rw_l;
  logic [7:0] rx_byte_l;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_q <= I2CPSF_CTRL1_RST;
      stat_hi_q <= 8'h00;
      addr_q <= 8'h00;
      buf_q <= 8'h00;
      req_q <= 5'b0_0000;
      {start_q, stop_q, rw_q, bf_q, ifl_q, mtx_q, addr_dirty_q, txp_q} <= 8'h00;
      cmd_tog_q <= 1'b0;
      cmd_q <= '{kind: I2CPSF_CMD_ADDR, data: 8'h00};
      // Tracking the synced toggles through reset keeps a stale toggle from posing as an event.
      evp_q <= evs;
    end else begin
      evp_q <= evs;
      if (wr_c1) ctrl1_q <= wdat_q;
      if (wr_st) stat_hi_q <= {wdat_q[7:6], 6'b00_0000};
      if (wr_adr) begin
        addr_q <= wdat_q;
        addr_dirty_q <= 1'b1;
      end
      if (wr_irq & wdat_q[0]) ifl_q <= 1'b0;
      if (ev.ack | wr_c2) req_q <= (req_q & ~req_done) | (wr_c2 ? wdat_q[4:0] : 5'b0_0000);
      if (issue) begin
        cmd_tog_q <= ~cmd_tog_q;
        cmd_q <= '{kind: i2cpsf_cmd_kind_t'(issue_kind), data: addr_dirty_q ? addr_q : buf_q};
        if (addr_dirty_q) addr_dirty_q <= 1'b0;
        else if (~|req_q[2:0] & txp_q) txp_q <= 1'b0;
      end
      if (wr_buf) begin
        if (bf_q | (master & (cmd_busy | txp_q))) ctrl1_q[I2CPSF_C1_WCOL] <= 1'b1;
        else begin
          buf_q <= wdat_q;
          bf_q <= 1'b1;
          txp_q <= master;
          mtx_q <= master;
        end
      end
      if (rd_buf & ~mtx_q) bf_q <= 1'b0;
      if (ev.txd) begin
        bf_q <= 1'b0;
        mtx_q <= 1'b0;
        rw_q <= 1'b0;
      end
      if (ev.rx) begin
        buf_q <= rx_byte_l;
        bf_q <= 1'b1;
        ifl_q <= 1'b1;
        if (bf_q) ctrl1_q[I2CPSF_C1_OVF] <= 1'b1;
      end
      if (ev.start) begin
        start_q <= 1'b1;
        stop_q <= 1'b0;
      end
      if (ev.stop) begin
        stop_q <= 1'b1;
        start_q <= 1'b0;
      end
      if (~master & (ev.start | ev.stop | ev.nack)) rw_q <= 1'b0;
      if (~master & ev.match) rw_q <= rx_rw_l;
      if (master & wr_buf & ~bf_q & ~cmd_busy & ~txp_q) rw_q <= 1'b1;
      if (~en) begin
        {start_q, stop_q, rw_q, bf_q, mtx_q, txp_q} <= 6'b00_0000;
        req_q <= 5'b0_0000;
      end
    end
  end
  // ==========================================================================
  // Link clock domain
  logic [2:0] lctl;
  logic [1:0] lpin;
  logic lcmd_tog;
  logic [1:0] lpin_q;
  logic lcmd_seen_q;
  i2cpsf_evt_t levt_q;
  i2cpsf_lstate_t lst_q;
  logic [15:0] lcnt_q;
  logic [8:0] lout_q;
  logic [7:0] lin_q, lown_q, lssr_q;
  logic [3:0] lbit_q, lnum_q, lsbit_q;
  i2cpsf_cmd_kind_t lkind_q;
  logic lmscl_q, lmsda_q, lsack_q, lsmatch_q, lsaddr_q, scl_oe_q, sda_oe_q;
  i2cpsf_sync #(.W(3)) u_ctl_sync (.clk(link_clk), .din({aresetn, en, master}), .dout(lctl));
  i2cpsf_sync #(.W(2)) u_pin_sync (.clk(link_clk), .din({scl_i, sda_i}), .dout(lpin));
  i2cpsf_sync #(.W(1)) u_cmd_sync (.clk(link_clk), .din(cmd_tog_q), .dout(lcmd_tog));
  i2cpsf_sync #(.W(7)) u_evt_sync (.clk(aclk), .din(levt_q), .dout(evs));
  // Busy lasts until the cycle after the acknowledge, so the finished request is gone before reissue.
  assign cmd_busy = cmd_tog_q ^ evp_q.ack;
  wire lrun = lctl[2] & lctl[1];
  wire lmst = lctl[0];
  wire lstart = lpin_q[1] & lpin[1] & lpin_q[0] & ~lpin[0];
  wire lstop = lpin_q[1] & lpin[1] & ~lpin_q[0] & lpin[0];
  wire lrise = ~lpin_q[1] & lpin[1];
  wire lfall = lpin_q[1] & ~lpin[1];
  wire lnew = lcmd_tog ^ lcmd_seen_q;
  wire ltick = (lcnt_q == 16'(HALF_BIT - 1));
  wire l9th = (lsbit_q == I2CPSF_BITS_RX);
  wire lslave = ~lmst & lrun;
  always_ff @(posedge link_clk) begin
    lpin_q <= lpin;
    if (!lrun) begin
      lst_q <= I2CPSF_L_IDLE;
      {lmscl_q, lmsda_q, lsack_q, lsmatch_q, lsaddr_q, scl_oe_q, sda_oe_q} <= 7'h00;
      lcnt_q <= 16'h0000;
      lbit_q <= 4'h0;
      lsbit_q <= 4'h0;
      lnum_q <= 4'h0;
      lout_q <= I2CPSF_OUT_IDLE;
      lin_q <= 8'h00;
      lssr_q <= 8'h00;
      lkind_q <= I2CPSF_CMD_ADDR;
      // Toggles other than ack restart only under reset, ack follows the command toggle; a plain disable keeps the rest so no stale event appears.
      if (!lctl[2]) levt_q <= '0;
      lcmd_seen_q <= lcmd_tog;
      levt_q.ack <= lcmd_tog;
      lown_q <= lown_q;
    end else begin
      scl_oe_q <= lmscl_q;
      sda_oe_q <= lmsda_q | lsack_q;
      lcnt_q <= (lst_q == I2CPSF_L_IDLE || ltick) ? 16'h0000 : lcnt_q + 16'h0001;
      if (lstart) levt_q.start <= ~levt_q.start;
      if (lstop) levt_q.stop <= ~levt_q.stop;
      if (lstart | lstop) begin
        lsbit_q <= 4'h0;
        lsaddr_q <= lstart;
        lsmatch_q <= 1'b0;
        lsack_q <= 1'b0;
      end else if (lslave & lrise) begin
        lsbit_q <= l9th ? 4'h0 : lsbit_q + 4'h1;
        if (!l9th) lssr_q <= {lssr_q[6:0], lpin[0]};
        if (l9th) lsaddr_q <= 1'b0;
        if (l9th & lpin[0] & lsmatch_q) levt_q.nack <= ~levt_q.nack;
      end else if (lslave & lfall) begin
        if (l9th & lsaddr_q & (lssr_q[7:1] == lown_q[6:0])) begin
          lsmatch_q <= 1'b1;
          lsack_q <= 1'b1;
          rx_rw_l <= lssr_q[0];
          levt_q.match <= ~levt_q.match;
        end else if (l9th & ~lsaddr_q & lsmatch_q & ~rx_rw_l) begin
          lsack_q <= 1'b1;
          rx_byte_l <= lssr_q;
          levt_q.rx <= ~levt_q.rx;
        end else if (lsbit_q == 4'h0) lsack_q <= 1'b0;
      end
      case (lst_q)
        I2CPSF_L_IDLE: begin
          if (lnew) begin
            lcmd_seen_q <= lcmd_tog;
            lkind_q <= cmd_q.kind;
            lbit_q <= 4'h0;
            lin_q <= 8'h00;
            case (cmd_q.kind)
              I2CPSF_CMD_ADDR: begin
                lown_q <= cmd_q.data;
                levt_q.ack <= ~levt_q.ack;
              end
              I2CPSF_CMD_START, I2CPSF_CMD_RSTART: begin
                {lmscl_q, lmsda_q} <= 2'b00;
                lst_q <= I2CPSF_L_ST1;
              end
              I2CPSF_CMD_STOP: begin
                {lmscl_q, lmsda_q} <= 2'b11;
                lst_q <= I2CPSF_L_SP1;
              end
              I2CPSF_CMD_TX: begin
                lout_q <= {cmd_q.data, 1'b1};
                lnum_q <= I2CPSF_BITS_TX;
                lst_q <= I2CPSF_L_LO;
              end
              I2CPSF_CMD_RX: begin
                lout_q <= I2CPSF_OUT_IDLE;
                lnum_q <= I2CPSF_BITS_RX;
                lst_q <= I2CPSF_L_LO;
              end
              default: begin
                lout_q <= {1'b0, 8'hFF};
                lnum_q <= I2CPSF_BITS_ACK;
                lst_q <= I2CPSF_L_LO;
              end
            endcase
          end
        end
        I2CPSF_L_ST1: if (ltick) begin
          lmsda_q <= 1'b1;
          lst_q <= I2CPSF_L_ST2;
        end
        I2CPSF_L_ST2: if (ltick) begin
          lmscl_q <= 1'b1;
          lst_q <= I2CPSF_L_IDLE;
          levt_q.ack <= ~levt_q.ack;
        end
        I2CPSF_L_LO: begin
          lmscl_q <= 1'b1;
          lmsda_q <= ~lout_q[8];
          if (ltick) lst_q <= I2CPSF_L_HI;
        end
        I2CPSF_L_HI: begin
          lmscl_q <= 1'b0;
          if (ltick) begin
            lin_q <= {lin_q[6:0], lpin[0]};
            lout_q <= {lout_q[7:0], 1'b1};
            lbit_q <= lbit_q + 4'h1;
            lst_q <= I2CPSF_L_LO;
            if (lbit_q + 4'h1 == lnum_q) begin
              lmscl_q <= 1'b1;
              lst_q <= I2CPSF_L_IDLE;
              levt_q.ack <= ~levt_q.ack;
              if (lkind_q == I2CPSF_CMD_TX) levt_q.txd <= ~levt_q.txd;
              if (lkind_q == I2CPSF_CMD_RX) begin
                rx_byte_l <= {lin_q[6:0], lpin[0]};
                levt_q.rx <= ~levt_q.rx;
              end
            end
          end
        end
        I2CPSF_L_SP1: if (ltick) begin
          lmscl_q <= 1'b0;
          lst_q <= I2CPSF_L_SP2;
        end
        I2CPSF_L_SP2: if (ltick) begin
          lmsda_q <= 1'b0;
          lst_q <= I2CPSF_L_IDLE;
          levt_q.ack <= ~levt_q.ack;
        end
        default: lst_q <= I2CPSF_L_IDLE;
      endcase
    end
  end
  // ==========================================================================
  // Outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign port_owns_pins = ctrl1_q[I2CPSF_C1_EN];
  // ==========================================================================
  // Checks
  sequence s_tx_write;
    wr_buf & ~bf_q & master & ~cmd_busy & ~txp_q & en;
  endsequence
  chk_start_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ev.start & ~ev.stop & en |=> start_q & ~stop_q) else $error("start flag not set");
  chk_stop_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ev.stop & en |=> stop_q & ~start_q) else $error("stop flag not set");
  chk_disable_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    ~en |=> ~start_q & ~stop_q & ~bf_q) else $error("flags survive disable");
  chk_slave_dir_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    ev.match & ~ev.start & ~ev.stop & ~master & en |=> rw_q == $past(rx_rw_l))
    else $error("direction not latched");
  chk_master_dir_run: assert property (@(posedge aclk) disable iff (!aresetn)
    s_tx_write |=> rw_q & mtx_q & active) else $error("master direction not set");
  chk_tx_buffer_empty: assert property (@(posedge aclk) disable iff (!aresetn)
    ev.txd & ~ev.rx & en |=> ~bf_q ##0 ~mtx_q) else $error("buffer still full");
  chk_pins_released: assert property (@(posedge link_clk)
    ~lrun |=> ~scl_oe_q & ~sda_oe_q) else $error("pins driven while disabled");
  chk_rx_moves_byte: assert property (@(posedge aclk) disable iff (!aresetn)
    ev.rx & en |=> buf_q == $past(rx_byte_l) && ifl_q && bf_q) else $error("byte not moved");
endmodule : i2cpsf_top

// ---- i2cpsf_peer.sv ----
/*
  Behavioural peer on the two-wire bus: a master that frames bytes towards the port.
  Assumes open-drain wires with pull-ups; it changes its pulls on the link clock.
*/
module i2cpsf_peer (
  input wire logic link_clk,
  input wire logic dut_scl_oe,
  input wire logic dut_sda_oe,
  output logic scl_i,
  output logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_low;
  logic sda_low;
  // ==========================================================================
  // Wires
  // A wire that nobody pulls down reads high through its pull-up.
  assign scl_i = !(scl_low | dut_scl_oe);
  assign sda_i = !(sda_low | dut_sda_oe);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // ==========================================================================
  // Framing
  // The phases are slower than the port's own bit so that its samplers see every change.
  task automatic gap;
    repeat (10) @(posedge link_clk);
  endtask : gap
  task automatic frame_start;
    sda_low <= 1'b0;
    gap();
    scl_low <= 1'b0;
    gap();
    sda_low <= 1'b1;
    gap();
    scl_low <= 1'b1;
    gap();
  endtask : frame_start
  task automatic frame_stop;
    sda_low <= 1'b1;
    gap();
    scl_low <= 1'b0;
    gap();
    sda_low <= 1'b0;
    gap();
  endtask : frame_stop
  // Data changes only while the clock is held low; the ninth clock leaves data free.
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= !b[i];
      gap();
      scl_low <= 1'b0;
      gap();
      scl_low <= 1'b1;
      gap();
    end
    sda_low <= 1'b0;
    gap();
    scl_low <= 1'b0;
    gap();
    scl_low <= 1'b1;
    gap();
  endtask : send_byte
endmodule : i2cpsf_peer

// ---- tb.sv ----
/*
  Self-checking bench of the port status block: register table, slave and master flows.
  Assumes the peer model on the wires and a shortened half bit of four link clocks.
*/
module tb
  import i2cpsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [1:0] resp;
  } i2cpsf_row_t;
  localparam i2cpsf_row_t ROWS [10] = '{
    '{1'b0, I2CPSF_OFS_CTRL1, 8'h00, I2CPSF_RESP_OKAY}, '{1'b0, I2CPSF_OFS_STATUS, 8'h00, 2'b00},
    '{1'b1, I2CPSF_OFS_STATUS, 8'hFF, 2'b00}, '{1'b0, I2CPSF_OFS_STATUS, 8'hC0, 2'b00},
    '{1'b1, I2CPSF_OFS_STATUS, 8'h00, 2'b00}, '{1'b1, I2CPSF_OFS_CTRL1, 8'h36, 2'b00},
    '{1'b0, I2CPSF_OFS_CTRL1, 8'h36, 2'b00}, '{1'b1, I2CPSF_OFS_OWNADDR, 8'h2A, 2'b00},
    '{1'b0, 8'h18, 8'h00, I2CPSF_RESP_SLVERR}, '{1'b1, 8'h1C, 8'h00, I2CPSF_RESP_SLVERR}};
  logic aclk, aresetn, link_clk, awv, awr, wv, wrdy, bv, bry, arv, arr, rv, rry;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdata, v;
  logic [1:0] bresp, rresp, rs;
  logic scl_i, sda_i, scl_oe, sda_oe, owns, saw_drive;
  int miscompares, total_checks, cyc;
  i2cpsf_top #(.HALF_BIT(4)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .port_owns_pins(owns));
  i2cpsf_peer peer (.link_clk(link_clk), .dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe),
    .scl_i(scl_i), .sda_i(sda_i));
  // ==========================================================================
  // Clocks, timeout and helpers
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  always @(posedge link_clk) if (scl_oe === 1'b1) saw_drive <= 1'b1;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out;
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset
  // Holds each channel until its own handshake edge, then waits for the answer.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    if (w) begin
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= {24'h00_0000, d};
      bry <= 1'b1;
    end else begin
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
    end
    while (!done) begin
      @(posedge aclk);
      if (awv && awr === 1'b1) awv <= 1'b0;
      if (wv && wrdy === 1'b1) wv <= 1'b0;
      if (arv && arr === 1'b1) arv <= 1'b0;
      if (w ? bv === 1'b1 : rv === 1'b1) begin
        done = 1'b1;
        v = rdata;
        rs = w ? bresp : rresp;
        bry <= 1'b0;
        rry <= 1'b0;
      end
    end
  endtask : xfer
  // Reads until the value shows up; the bound only guards against a hang.
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      xfer(1'b0, a, 8'h00);
      n++;
    end while (v !== exp && n < 300);
    chk(v, exp);
  endtask : expect_reg
  // ==========================================================================
  // Main sequence
  initial begin
    {awv, wv, bry, arv, rry, saw_drive} = '0;
    {awa, ara, wd} = '0;
    aresetn = 1'b0;
    do_reset();
    foreach (ROWS[i]) begin
      xfer(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
      chk({30'h0000_0000, rs}, {30'h0000_0000, ROWS[i].resp});
      if (!ROWS[i].wr) chk(v, {24'h00_0000, ROWS[i].d});
    end
    chk({31'h0000_0000, owns}, 32'h0000_0001);
    peer.frame_start();
    expect_reg(I2CPSF_OFS_STATUS, 32'h0000_0008);
    peer.send_byte(8'h55);
    expect_reg(I2CPSF_OFS_STATUS, 32'h0000_000C);
    peer.send_byte(8'hFF);
    expect_reg(I2CPSF_OFS_STATUS, 32'h0000_0008);
    peer.frame_stop();
    expect_reg(I2CPSF_OFS_STATUS, 32'h0000_0010);
    peer.frame_start();
    peer.send_byte(8'h54);
    peer.send_byte(8'hA5);
    expect_reg(I2CPSF_OFS_STATUS, 32'h0000_0009);
    expect_reg(I2CPSF_OFS_IRQ, 32'h0000_0001);
    expect_reg(I2CPSF_OFS_BUFFER, 32'h0000_00A5);
    expect_reg(I2CPSF_OFS_STATUS, 32'h0000_0008);
    xfer(1'b1, I2CPSF_OFS_IRQ, 8'h01);
    expect_reg(I2CPSF_OFS_IRQ, 32'h0000_0000);
    peer.frame_stop();
    xfer(1'b1, I2CPSF_OFS_CTRL1, 8'h28);
    xfer(1'b1, I2CPSF_OFS_CTRL2, 8'h01);
    expect_reg(I2CPSF_OFS_CTRL2, 32'h0000_0000);
    expect_reg(I2CPSF_OFS_STATUS, 32'h0000_0008);
    xfer(1'b1, I2CPSF_OFS_BUFFER, 8'h5A);
    expect_reg(I2CPSF_OFS_STATUS, 32'h0000_000D);
    expect_reg(I2CPSF_OFS_IRQ, 32'h0000_0002);
    expect_reg(I2CPSF_OFS_STATUS, 32'h0000_0008);
    chk({31'h0000_0000, saw_drive}, 32'h0000_0001);
    xfer(1'b1, I2CPSF_OFS_CTRL2, 8'h08);
    expect_reg(I2CPSF_OFS_CTRL2, 32'h0000_0000);
    expect_reg(I2CPSF_OFS_BUFFER, 32'h0000_00FF);
    xfer(1'b1, I2CPSF_OFS_CTRL2, 8'h10);
    expect_reg(I2CPSF_OFS_CTRL2, 32'h0000_0000);
    xfer(1'b1, I2CPSF_OFS_CTRL2, 8'h04);
    expect_reg(I2CPSF_OFS_CTRL2, 32'h0000_0000);
    expect_reg(I2CPSF_OFS_STATUS, 32'h0000_0010);
    xfer(1'b1, I2CPSF_OFS_CTRL1, 8'h00);
    expect_reg(I2CPSF_OFS_STATUS, 32'h0000_0000);
    chk({31'h0000_0000, owns}, 32'h0000_0000);
    xfer(1'b1, I2CPSF_OFS_CTRL1, 8'h28);
    do_reset();
    expect_reg(I2CPSF_OFS_CTRL1, 32'h0000_0000);
    chk({31'h0000_0000, owns}, 32'h0000_0000);
    close_out();
  end
endmodule : tb
